// ---- lcd_serial_instruction_decoder.sv ----
`timescale 1ns/10ps
module lcd_serial_instruction_decoder #(
  parameter int BURST_EXEC_TICKS = 9         // Burst-step RAM write time, timebase ticks
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   frame_select_i,      // Frame select pin
  input  wire logic                   serial_bit_strobe_i, // Bit strobe pin
  input  wire logic                   serial_data_in_i,    // Serial data pin
  input  wire logic                   ext_tick_rate_i,     // External timebase clock pin
  input  wire logic                   key_scan_active_i,   // Key scan in progress
  output lcd_cmd_pkg::tech_cfg_t      tech_cfg_o,          // Display technique settings
  output lcd_cmd_pkg::onoff_cfg_t     onoff_cfg_o,         // On/off settings
  output logic [11:0]                 frame_div_o,         // Timebase divider for frame rate
  output logic                        shared_pin_common_o, // Shared seg/com pin is common
  output logic                        display_force_off_o, // Both data enables off
  output logic                        outputs_low_bias_o,  // All drivers at lowest bias
  output logic                        timebase_run_o,      // Timebase allowed to run
  output logic                        timebase_tick_o,     // One pulse per timebase period
  output logic                        busy_o,              // Instruction executing
  output logic                        step_burst_o,        // Last RAM write used burst step
  output logic                        cmd_valid_o,         // Pulse: cmd_o holds a new command
  output lcd_cmd_pkg::cmd_t           cmd_o                // Accepted frame for other units
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Opcode sits in D116..D119 with D116 as the most significant
  function automatic logic [3:0] get_opcode(input logic [119:0] f);
    get_opcode = {f[lcd_cmd_pkg::OPC_LSB], f[lcd_cmd_pkg::OPC_LSB+1],
                  f[lcd_cmd_pkg::OPC_LSB+2], f[lcd_cmd_pkg::OPC_LSB+3]};
  endfunction

  // Divider for a duty and rate pair; 11 never reaches here
  function automatic logic [11:0] rate_div(input logic duty, input logic lo, input logic hi);
    case ({hi, lo})
      2'b01:   rate_div = duty ? lcd_cmd_pkg::DIV9_MID  : lcd_cmd_pkg::DIV8_MID;
      2'b10:   rate_div = duty ? lcd_cmd_pkg::DIV9_FAST : lcd_cmd_pkg::DIV8_FAST;
      default: rate_div = duty ? lcd_cmd_pkg::DIV9_SLOW : lcd_cmd_pkg::DIV8_SLOW;
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers and edge detection
  // ==========================================================
  logic [3:0] pins_s;                         // Synchronised pins
  logic [3:0] pins_p;                         // Previous synchronised pins
  logic       strobe_rise;                    // Bit strobe rising edge
  logic       sel_rise;                       // Frame select rising edge
  logic       sel_fall;                       // Frame select falling edge
  logic       ext_rise;                       // External timebase rising edge

  pin_sync #(.WIDTH(4)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    ({ext_tick_rate_i, frame_select_i, serial_bit_strobe_i, serial_data_in_i}),
    .sync_o     (pins_s)
  );

  // Remember last sampled levels for edge finding
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_p <= 4'h0;
    end else begin
      pins_p <= pins_s;
    end
  end

  // Only rising strobe edges count, so the idle level is irrelevant
  assign strobe_rise = pins_s[1] & ~pins_p[1];
  assign sel_rise    = pins_s[2] & ~pins_p[2];
  assign sel_fall    = ~pins_s[2] & pins_p[2];
  assign ext_rise    = pins_s[3] & ~pins_p[3];

  // ==========================================================
  // Serial receiver
  // ==========================================================
  logic [7:0]   addr_sr_r;                    // Address shifter, first bit ends in bit 0
  logic [119:0] data_sr_r;                    // Frame shifter, D0 ends in bit 0
  logic [6:0]   bit_cnt_r;                    // Data bits seen, saturating
  logic         addr_ok_r;                    // Address matched at frame start
  logic         frame_done;                   // Whole addressed frame latched

  // Address bits shift while select is low, data bits while it is high
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_sr_r <= 8'h00;
      data_sr_r <= '0;
      bit_cnt_r <= 7'h00;
      addr_ok_r <= 1'b0;
    end else if (sel_rise) begin
      addr_ok_r <= (addr_sr_r == lcd_cmd_pkg::FRAME_ADDR);
      bit_cnt_r <= 7'h00;
    end else if (strobe_rise) begin
      if (pins_s[2]) begin
        data_sr_r <= {pins_s[0], data_sr_r[119:1]};
        if (bit_cnt_r != 7'h7F) begin
          bit_cnt_r <= bit_cnt_r + 7'h01;
        end
      end else begin
        addr_sr_r <= {pins_s[0], addr_sr_r[7:1]};
      end
    end
  end

  // Frame is taken at the select fall; a short or long frame is dropped
  assign frame_done = sel_fall & addr_ok_r
                    & (bit_cnt_r == 7'(lcd_cmd_pkg::FRAME_BITS));

  // ==========================================================
  // Acceptance filter
  // ==========================================================
  logic [3:0] opc;                            // Opcode of the latched frame
  logic       known_op;                       // Opcode defined
  logic       sleep_ok;                       // Allowed while sleeping
  logic       ram_wr;                         // Character or symbol RAM write
  logic       step_norm;                      // Normal step mode bits
  logic       step_burst;                     // Burst step mode bits
  logic       tech_seen_r;                    // Technique executed since reset
  logic       accept;                         // Frame executes this cycle
  logic [6:0] busy_cnt_r;                     // Remaining execution ticks
  logic [3:0] fld;                            // Field nibble D112..D115, D112 in bit 0

  assign opc        = get_opcode(data_sr_r);
  assign fld        = data_sr_r[lcd_cmd_pkg::FLD_LSB +: 4];
  assign known_op   = (opc >= lcd_cmd_pkg::OPC_TECH) && (opc <= lcd_cmd_pkg::OPC_PORT);
  assign sleep_ok   = (opc == lcd_cmd_pkg::OPC_ONOFF) || (opc == lcd_cmd_pkg::OPC_CONTRAST)
                    || (opc == lcd_cmd_pkg::OPC_PORT);
  assign ram_wr     = (opc == lcd_cmd_pkg::OPC_CHAR_WR) || (opc == lcd_cmd_pkg::OPC_SYM_WR);
  assign step_norm  = fld[0] & ~fld[1];
  assign step_burst = ~fld[0] & fld[1];

  // A frame landing while busy is dropped: the host owes the gap
  assign accept = frame_done & known_op & (busy_cnt_r == 7'h00)
                & (tech_seen_r | (opc == lcd_cmd_pkg::OPC_TECH))
                & (~onoff_cfg_o.sleep_request | sleep_ok)
                & (~ram_wr | step_norm | step_burst);

  // ==========================================================
  // Timebase: internal divider or external clock edges
  // ==========================================================
  logic [8:0] osc_cnt_r;                      // Internal oscillator model
  logic       osc_wrap;                       // Internal period elapsed

  // Sleep stops the timebase unless a scan or execution needs it
  assign timebase_run_o = ~onoff_cfg_o.sleep_request | key_scan_active_i
                        | (busy_cnt_r != 7'h00);
  assign osc_wrap       = (osc_cnt_r == 9'(lcd_cmd_pkg::OSC_DIV - 1));

  // Internal oscillator counts only while the timebase runs
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_cnt_r <= 9'h000;
    end else if (!timebase_run_o || tech_cfg_o.timebase_origin || osc_wrap) begin
      osc_cnt_r <= 9'h000;
    end else begin
      osc_cnt_r <= osc_cnt_r + 9'h001;
    end
  end

  // Tick source follows the programmed origin
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timebase_tick_o <= 1'b0;
    end else begin
      timebase_tick_o <= timebase_run_o
                       & (tech_cfg_o.timebase_origin ? ext_rise : osc_wrap);
    end
  end

  // ==========================================================
  // Execution timer in timebase ticks
  // ==========================================================
  logic [6:0] exec_ticks;                     // Load value for the accepted frame

  // Counting ticks makes every time stretch by 300/f at slower rates
  always_comb begin
    exec_ticks = 7'h00;
    case (opc)
      lcd_cmd_pkg::OPC_TECH:
        exec_ticks = tech_seen_r ? 7'h00 : 7'(lcd_cmd_pkg::FIRST_EXEC_TICKS);
      lcd_cmd_pkg::OPC_ONOFF:
        exec_ticks = fld[3] ? 7'(lcd_cmd_pkg::SHORT_EXEC_TICKS) : 7'h00;
      lcd_cmd_pkg::OPC_CHAR_WR, lcd_cmd_pkg::OPC_SYM_WR:
        exec_ticks = step_burst ? 7'(BURST_EXEC_TICKS)
                                : 7'(lcd_cmd_pkg::SHORT_EXEC_TICKS);
      lcd_cmd_pkg::OPC_SHIFT, lcd_cmd_pkg::OPC_SET_ADDR, lcd_cmd_pkg::OPC_GLYPH_WR:
        exec_ticks = 7'(lcd_cmd_pkg::SHORT_EXEC_TICKS);
      default:
        exec_ticks = 7'h00;
    endcase
  end

  // Load on accept, count down on each tick
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_cnt_r <= 7'h00;
    end else if (accept) begin
      busy_cnt_r <= exec_ticks;
    end else if (timebase_tick_o && busy_cnt_r != 7'h00) begin
      busy_cnt_r <= busy_cnt_r - 7'h01;
    end
  end

  assign busy_o = (busy_cnt_r != 7'h00);

  // ==========================================================
  // Display technique and on/off state
  // ==========================================================
  logic rate_rsvd;                            // Rate bits 11 received

  assign rate_rsvd = fld[1] & fld[2];

  // Technique fields; reserved rate keeps the old rate bits, divider recomputed with the new duty
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tech_cfg_o  <= lcd_cmd_pkg::TECH_RST;
      tech_seen_r <= 1'b0;
      frame_div_o <= lcd_cmd_pkg::DIV8_SLOW;
    end else if (accept && opc == lcd_cmd_pkg::OPC_TECH) begin
      tech_seen_r                <= 1'b1;
      tech_cfg_o.duty_select     <= fld[0];
      tech_cfg_o.timebase_origin <= fld[3];
      if (!rate_rsvd) begin
        tech_cfg_o.frame_rate_sel_lo <= fld[1];
        tech_cfg_o.frame_rate_sel_hi <= fld[2];
        frame_div_o <= rate_div(fld[0], fld[1], fld[2]);
      end else begin
        frame_div_o <= rate_div(fld[0], tech_cfg_o.frame_rate_sel_lo,
                                tech_cfg_o.frame_rate_sel_hi);
      end
    end
  end

  // On/off fields straight from the frame
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      onoff_cfg_o <= lcd_cmd_pkg::ONOFF_RST;
    end else if (accept && opc == lcd_cmd_pkg::OPC_ONOFF) begin
      onoff_cfg_o.digit_on_flags <= data_sr_r[lcd_cmd_pkg::DIGIT_LSB +: lcd_cmd_pkg::DIGITS];
      onoff_cfg_o.character_text       <= fld[0];
      onoff_cfg_o.extra_symbol_bits    <= fld[1];
      onoff_cfg_o.outputs_forced_blank <= fld[2];
      onoff_cfg_o.sleep_request        <= fld[3];
    end
  end

  // Drive-level summaries for the waveform generator
  assign shared_pin_common_o = tech_cfg_o.duty_select;
  assign display_force_off_o = ~onoff_cfg_o.character_text
                             & ~onoff_cfg_o.extra_symbol_bits;
  assign outputs_low_bias_o  = onoff_cfg_o.outputs_forced_blank
                             | onoff_cfg_o.sleep_request;

  // ==========================================================
  // Command hand-off to RAM, shift, contrast and port units
  // ==========================================================
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_valid_o  <= 1'b0;
      cmd_o        <= '0;
      step_burst_o <= 1'b0;
    end else begin
      cmd_valid_o <= accept;
      if (accept) begin
        cmd_o.opcode <= opc;
        cmd_o.bits   <= data_sr_r;
        if (ram_wr) begin
          step_burst_o <= step_burst;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  addr_filter_a: assert property (accept |-> addr_ok_r)
    else $error("frame accepted with foreign address");
  first_tech_a: assert property (accept && !tech_seen_r |-> opc == lcd_cmd_pkg::OPC_TECH
      ##1 busy_cnt_r == 7'(lcd_cmd_pkg::FIRST_EXEC_TICKS))
    else $error("first instruction not technique or wrong time");
  sleep_filter_a: assert property (accept && onoff_cfg_o.sleep_request |-> sleep_ok)
    else $error("disallowed instruction executed in sleep");
  onoff_time_a: assert property (accept && opc == lcd_cmd_pkg::OPC_ONOFF
      |=> busy_cnt_r == (onoff_cfg_o.sleep_request ? 7'(lcd_cmd_pkg::SHORT_EXEC_TICKS) : 7'h00))
    else $error("on/off execution time wrong");
  rate_keep_a: assert property (accept && opc == lcd_cmd_pkg::OPC_TECH && rate_rsvd
      |=> $stable({tech_cfg_o.frame_rate_sel_lo, tech_cfg_o.frame_rate_sel_hi}))
    else $error("reserved rate changed the rate");
  div_slow_a: assert property (accept && opc == lcd_cmd_pkg::OPC_TECH
      && fld[2:0] == 3'b000 |=> frame_div_o == lcd_cmd_pkg::DIV8_SLOW)
    else $error("wrong divider for 1/8 duty slow rate");
  unknown_op_a: assert property (frame_done && !known_op |-> !accept
      ##1 !cmd_valid_o && $stable(onoff_cfg_o))
    else $error("unknown opcode had an effect");
  tick_count_a: assert property (busy_o && !timebase_tick_o && !accept
      |=> $stable(busy_cnt_r))
    else $error("execution counted without a timebase tick");
  blank_drive_a: assert property (accept && opc == lcd_cmd_pkg::OPC_ONOFF && fld[2]
      |=> outputs_low_bias_o)
    else $error("blank request did not force lowest bias");

endmodule // lcd_serial_instruction_decoder

// ---- lcd_cmd_pkg.sv ----
// Behaviour
// - Sample on strobe rise, latch on select fall
// - Strobe idle level low or high both work
// - Accept only frames addressed 42H
// - Receive 120 instruction bits, D0 first
// - Opcode 0001 sets duty, rate, timebase origin
// - Technique instruction first; first takes 108us
// - Execution times scale inversely with timebase
// - On/off takes 27us only when sleeping
// - Duty select picks 1/8 or 1/9, shared pin
// - Rate bits choose timebase divider per duty
// - Origin picks internal oscillator or external clock
// - Opcode 0010 carries digits, enables, blank, sleep
// - RAM writes differ by normal/burst step mode
// - Two data enables gate text, symbols; both off
// - Forced blank holds outputs at lowest bias
// - Sleep stops timebase, blanks, limits instructions
package lcd_cmd_pkg;

  // ==========================================================
  // Frame layout
  // ==========================================================
  localparam logic [7:0] FRAME_ADDR      = 8'h42;   // Address this receiver answers
  localparam int         FRAME_BITS      = 120;     // Instruction bits per frame
  localparam int         OPC_LSB         = 116;     // First opcode bit position
  localparam int         FLD_LSB         = 112;     // First field bit of the low nibble
  localparam int         DIGIT_LSB       = 96;      // First digit enable
  localparam int         DIGITS          = 13;      // Number of digit enables

  // ==========================================================
  // Opcodes, read as {D116,D117,D118,D119}
  // ==========================================================
  localparam logic [3:0] OPC_TECH        = 4'h1;    // Display technique
  localparam logic [3:0] OPC_ONOFF       = 4'h2;    // Display on/off control
  localparam logic [3:0] OPC_SHIFT       = 4'h3;    // Display shift
  localparam logic [3:0] OPC_SET_ADDR    = 4'h4;    // Address counter load
  localparam logic [3:0] OPC_CHAR_WR     = 4'h5;    // Character RAM write
  localparam logic [3:0] OPC_SYM_WR      = 4'h6;    // Symbol RAM write
  localparam logic [3:0] OPC_GLYPH_WR    = 4'h7;    // Glyph RAM write
  localparam logic [3:0] OPC_CONTRAST    = 4'h8;    // Contrast setting
  localparam logic [3:0] OPC_PORT        = 4'h9;    // Port state setting

  // ==========================================================
  // Frame rate dividers
  // ==========================================================
  localparam logic [11:0] DIV8_SLOW      = 12'hC00; // 3072
  localparam logic [11:0] DIV8_MID       = 12'h600; // 1536
  localparam logic [11:0] DIV8_FAST      = 12'h300; // 768
  localparam logic [11:0] DIV9_SLOW      = 12'hD80; // 3456
  localparam logic [11:0] DIV9_MID       = 12'h6C0; // 1728
  localparam logic [11:0] DIV9_FAST      = 12'h360; // 864

  // ==========================================================
  // Timing: execution counted in timebase ticks so it scales
  // ==========================================================
  localparam int TB_NOM_KHZ       = 300;            // Nominal timebase
  localparam int CORE_KHZ         = 100000;         // Core clock rate
  localparam int FIRST_EXEC_NS    = 108000;         // First technique execution
  localparam int SHORT_EXEC_NS    = 27000;          // Ordinary execution
  localparam int OSC_DIV          = CORE_KHZ / TB_NOM_KHZ;  // Internal tick period
  localparam int FIRST_EXEC_TICKS = (FIRST_EXEC_NS * TB_NOM_KHZ + 999999) / 1000000;
  localparam int SHORT_EXEC_TICKS = (SHORT_EXEC_NS * TB_NOM_KHZ + 999999) / 1000000;

  // ==========================================================
  // Carriers and reset values
  // ==========================================================
  typedef struct packed {
    logic       duty_select;        // 0: 1/8 duty, 1: 1/9 duty
    logic       frame_rate_sel_lo;  // Rate select low bit
    logic       frame_rate_sel_hi;  // Rate select high bit
    logic       timebase_origin;    // 0: internal, 1: external
  } tech_cfg_t;

  typedef struct packed {
    logic [12:0] digit_on_flags;       // Digit 1 in bit 0
    logic        character_text;       // Text data enable
    logic        extra_symbol_bits;    // Symbol data enable
    logic        outputs_forced_blank; // Hold outputs at lowest bias
    logic        sleep_request;        // Sleep mode
  } onoff_cfg_t;

  typedef struct packed {
    logic [3:0]   opcode;           // Decoded opcode
    logic [119:0] bits;             // Whole frame, D0 in bit 0
  } cmd_t;

  localparam tech_cfg_t  TECH_RST  = '0;            // 1/8 duty, slow rate, internal
  localparam onoff_cfg_t ONOFF_RST = '0;            // Display off, awake

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser for pins from outside the core clock
// ==========================================================
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;                  // First stage, read only by the second

  // One pair of flops per pin
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta_r[g] <= 1'b0;
        sync_o[g] <= 1'b0;
      end else begin
        meta_r[g] <= async_i[g];
        sync_o[g] <= meta_r[g];
      end
    end
  end

endmodule // pin_sync

// ---- lcd_host_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Host side of the three-wire serial link
// ==========================================================
module lcd_host_model (
  output logic frame_select_o,      // Low: address phase, high: data phase
  output logic serial_bit_strobe_o, // Stands still between frames
  output logic serial_data_in_o     // Inverted once released, never left stale
);
  // Idle pins at time zero
  initial begin
    frame_select_o      = 1'b0;
    serial_bit_strobe_o = 1'b0;
    serial_data_in_o    = 1'b0;
  end

  // One bit: data set while strobe is low, taken at the rising edge
  task automatic shift_bit(input logic b);
    serial_bit_strobe_o = 1'b0;
    serial_data_in_o    = b;
    #62.5;
    serial_bit_strobe_o = 1'b1;
    #62.5;
  endtask

  // Whole transfer: address LSB first, then Instruction_bits, then select falls
  task automatic send_frame(input logic [7:0] addr, input logic [119:0] bits,
                            input logic idle);
    frame_select_o = 1'b0;
    for (int i = 0; i < 8; i++) begin
      shift_bit(addr[i]);
    end
    frame_select_o = 1'b1;
    for (int i = 0; i < 120; i++) begin
      shift_bit(bits[i]);
    end
    serial_bit_strobe_o = idle;
    #62.5;
    frame_select_o   = 1'b0;
    serial_data_in_o = ~serial_data_in_o;
  endtask
endmodule // lcd_host_model

// ---- lcd_serial_instruction_decoder_tb.sv ----
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the serial instruction decoder
// ==========================================================
module lcd_serial_instruction_decoder_tb;
  logic                    core_clk_i = 1'b0;
  logic                    rst_b_i = 1'b0;
  logic                    frame_select_i, serial_bit_strobe_i, serial_data_in_i;
  logic                    ext_tick_rate_i = 1'b0;   // External timebase pin, toggled only in t_ext_clock
  logic                    key_scan_active_i = 1'b0; // Key scan raised only in t_sleep
  lcd_cmd_pkg::tech_cfg_t  tech_cfg_o;
  lcd_cmd_pkg::onoff_cfg_t onoff_cfg_o;
  lcd_cmd_pkg::cmd_t       cmd_o;
  logic [11:0]             frame_div_o;
  logic                    shared_pin_common_o, display_force_off_o, outputs_low_bias_o;
  logic                    timebase_run_o, timebase_tick_o, busy_o, step_burst_o, cmd_valid_o;
  int                      bad_count = 0;
  int                      num_checks = 0;
  logic                    seen;
  int                      n;
  int                      ticks = 0;                // Timebase ticks seen so far

  always #5 core_clk_i = ~core_clk_i;

  // Count timebase pulses; read before the edge's own update lands
  always @(posedge core_clk_i) begin
    if (timebase_tick_o === 1'b1) ticks <= ticks + 1;
  end
  lcd_host_model host (.frame_select_o(frame_select_i), .serial_bit_strobe_o(serial_bit_strobe_i),
                       .serial_data_in_o(serial_data_in_i));
  lcd_serial_instruction_decoder dut (.core_clk_i, .rst_b_i, .frame_select_i,
    .serial_bit_strobe_i, .serial_data_in_i, .ext_tick_rate_i, .key_scan_active_i,
    .tech_cfg_o, .onoff_cfg_o, .frame_div_o, .shared_pin_common_o, .display_force_off_o,
    .outputs_low_bias_o, .timebase_run_o, .timebase_tick_o, .busy_o, .step_burst_o,
    .cmd_valid_o, .cmd_o);

  // Value compare; case equality so unknowns never match
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One frame, then a bounded watch for the acceptance pulse
  task automatic send(input logic [7:0] addr, input logic [7:0] code, input logic [12:0] dg,
                      input logic idle);
    @(negedge core_clk_i);
    host.send_frame(addr, {code, 3'h0, dg, 96'h0}, idle);
    seen = 1'b0;
    repeat (20) begin
      @(negedge core_clk_i);
      if (cmd_valid_o === 1'b1) seen = 1'b1;
    end
  endtask

  // Execution length in cycles; bounded so a stuck flag cannot hang
  task automatic busy_len();
    n = 0;
    while (busy_o === 1'b1 && n < 20000) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask

  // Code byte is D119 down to D112 in every scenario below
  // Reset values, then a non-technique frame that must be refused
  task automatic t_first_tech();
    chk(frame_div_o, 12'hC00);
    chk(display_force_off_o, 1);
    send(8'h42, 8'h45, 13'h1ABC, 1'b0);
    chk(seen, 0);
  endtask

  // First technique frame: fields, divider, hand-off, long execution
  task automatic t_tech();
    send(8'h42, 8'h83, 13'h0, 1'b0);
    chk(tech_cfg_o, 4'hC);
    chk(frame_div_o, 12'h6C0);
    chk(shared_pin_common_o, 1);
    chk({4'h0, cmd_o}, {4'h0, 4'h1, 8'h83, 112'h0});
    busy_len();
    chk(n > 32 * 333 - 40 && n <= 33 * 333, 1);
  endtask

  // Foreign address dropped, then on/off with the strobe idling high
  task automatic t_onoff();
    send(8'h43, 8'h45, 13'h1ABC, 1'b1);
    chk(seen, 0);
    send(8'h42, 8'h45, 13'h1ABC, 1'b1);
    chk(seen, 1);
    chk(onoff_cfg_o, {13'h1ABC, 4'hA});
    chk(outputs_low_bias_o, 1);
    chk(display_force_off_o, 0);
    chk(busy_o, 0);
  endtask

  // Reserved rate keeps the rate; an unknown opcode changes nothing
  task automatic t_rsvd_unknown();
    send(8'h42, 8'h86, 13'h0, 1'b0);
    chk(tech_cfg_o, 4'h4);
    chk(frame_div_o, 12'h600);
    send(8'h42, 8'hF0, 13'h1FFF, 1'b0);
    chk(seen, 0);
    chk(onoff_cfg_o, {13'h1ABC, 4'hA});
  endtask

  // RAM writes: bad step bits refused, then burst and normal step
  task automatic t_ram_step();
    send(8'h42, 8'hA0, 13'h0, 1'b0);
    chk(seen, 0);
    send(8'h42, 8'hA2, 13'h0, 1'b0);
    chk({seen, step_burst_o, busy_o}, 3'h7);
    chk(cmd_o.opcode, 4'h5);
    busy_len();
    send(8'h42, 8'hA1, 13'h0, 1'b0);
    chk({seen, step_burst_o}, 2'h2);
    busy_len();
    chk(n > 8 * 333 - 40 && n <= 9 * 333, 1);
  endtask

  // External timebase: only pin edges tick, then back to internal
  task automatic t_ext_clock();
    int t0;
    send(8'h42, 8'h8C, 13'h0, 1'b0);
    chk({tech_cfg_o, frame_div_o}, {4'h3, 12'h300});
    t0 = ticks;
    repeat (400) @(negedge core_clk_i);
    chk(ticks - t0, 0);
    repeat (10) begin
      repeat (5) @(negedge core_clk_i);
      ext_tick_rate_i = ~ext_tick_rate_i;
    end
    repeat (5) @(negedge core_clk_i);
    chk(ticks - t0, 5);
    send(8'h42, 8'h80, 13'h0, 1'b0);
    chk({tech_cfg_o, frame_div_o, shared_pin_common_o}, {4'h0, 12'hC00, 1'b0});
  endtask

  // Sleep: 27 us on/off, timebase stops unless a key scan runs
  task automatic t_sleep();
    send(8'h42, 8'h48, 13'h0, 1'b0);
    chk(busy_o, 1);
    busy_len();
    chk(n > 8 * 333 - 40 && n <= 9 * 333, 1);
    chk(outputs_low_bias_o, 1);
    chk(timebase_run_o, 0);
    key_scan_active_i = 1'b1;
    @(negedge core_clk_i);
    chk(timebase_run_o, 1);
    key_scan_active_i = 1'b0;
    send(8'h42, 8'h83, 13'h0, 1'b0);
    chk(seen, 0);
  endtask

  // Reset in mid-run brings back the power-on state
  task automatic t_reset();
    rst_b_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk({tech_cfg_o, onoff_cfg_o, frame_div_o}, {4'h0, 17'h0, 12'hC00});
    chk({outputs_low_bias_o, timebase_run_o, busy_o}, 3'h2);
    send(8'h42, 8'h45, 13'h1ABC, 1'b0);
    chk(seen, 0);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    t_first_tech();
    t_tech();
    t_onoff();
    t_rsvd_unknown();
    t_ram_step();
    t_ext_clock();
    t_sleep();
    t_reset();
    final_report();
  end

  // Watchdog: the whole run needs about half of this span
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
endmodule // lcd_serial_instruction_decoder_tb
